//--- hdl/rtc_params.svh
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define RTC_ADDR_CONFIG 8'ha1
`define RTC_ADDR_CENTI 8'ha2
`define RTC_ADDR_SEC 8'ha3
`define RTC_ADDR_MIN 8'ha4
`define RTC_ADDR_HOUR 8'ha5
`define RTC_ADDR_INTERVAL_COMPARE 8'ha6
`define RTC_ADDR_KEY 8'hc1
`define RTC_ADDR_POWER 8'hc5
`define RTC_ADDR_NOMTRIM 8'hf6
`define RTC_ADDR_THERMTRIM 8'hf7
`define RTC_ADDR_PINCFG 8'hff
// ----------------------------------------
// keys, fields, reset values
// ----------------------------------------
`define RTC_KEY_POWER 8'ha7
`define RTC_KEY_TIME 8'hea
`define RTC_RST_BYTE 8'h00
`define RTC_CFG_INTERVAL_ENABLE 0
`define RTC_CFG_SIT 1
`define RTC_CFG_ITS 3:2
`define RTC_CFG_HFMT 4
`define RTC_CFG_ALARM 5
`define RTC_CFG_MIDNIGHT 6
`define RTC_PIN_CALEN 7
`define RTC_PIN_FSEL 6:5
// ----------------------------------------
// timing
// ----------------------------------------
`define RTC_XTAL_HZ 32'h00008000
`define RTC_CENTI_INC_NORMAL 17'h00064
`define RTC_CENTI_INC_FAST 17'h030d4
`define RTC_ACC_WRAP 17'h08000
`define RTC_TRIM_LIMIT 9'sh07c
`define RTC_COMP_WINDOW 32'h000f4000
`endif

//--- hdl/rtc_pkg.sv
package rtc_pkg;
   typedef enum logic [1:0] {BASE_128HZ, BASE_SEC, BASE_MIN, BASE_HOUR} its_e;
   typedef enum logic [1:0] {CAL_1HZ, CAL_512HZ, CAL_500HZ, CAL_16K} cal_sel_e;
endpackage : rtc_pkg

//--- hdl/rtc_timekeeping_calibration.sv
`timescale 1ns/1ps
`include "rtc_params.svh"
module rtc_timekeeping_calibration #(
   parameter int COMP_WINDOW = `RTC_COMP_WINDOW
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic por_b,
   input wire logic xtal_in,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   input wire logic clock_irq_enable,
   input wire logic irq_ack,
   input wire logic deep_sleep_mode,
   output logic irq_req,
   output logic wake_req,
   output logic power_ctrl_we,
   output logic [7:0] power_ctrl_data,
   output logic cal_pin_out,
   output logic cal_pin_oe
);
   if (COMP_WINDOW < 512 || COMP_WINDOW > 1048575)
      $error("COMP_WINDOW out of range");
   // ----------------------------------------
   // crystal input: two-flop sync, then edge
   // ----------------------------------------
   logic xs1_reg, xs2_reg, xs3_reg;
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         xs1_reg <= 1'b0;
         xs2_reg <= 1'b0;
         xs3_reg <= 1'b0;
      end
      else
      begin
         xs1_reg <= xtal_in;
         xs2_reg <= xs1_reg;
         xs3_reg <= xs2_reg;
      end
   end
   logic xt_tick;
   assign xt_tick = xs2_reg & ~xs3_reg;
   // ----------------------------------------
   // trims survive warm reset
   // ----------------------------------------
   logic [7:0] nom_trim_reg, therm_trim_reg, nom_trim_next, therm_trim_next;
   always_comb
   begin
      nom_trim_next = nom_trim_reg;
      therm_trim_next = therm_trim_reg;
      if (sfr_wr && sfr_addr == `RTC_ADDR_NOMTRIM)
         nom_trim_next = sfr_wdata;
      if (sfr_wr && sfr_addr == `RTC_ADDR_THERMTRIM)
         therm_trim_next = sfr_wdata;
   end
   always_ff @(posedge clk or negedge por_b)
   begin
      if (!por_b)
      begin
         nom_trim_reg <= `RTC_RST_BYTE;
         therm_trim_reg <= `RTC_RST_BYTE;
      end
      else
      begin
         nom_trim_reg <= nom_trim_next;
         therm_trim_reg <= therm_trim_next;
      end
   end
   // ----------------------------------------
   // main state
   // ----------------------------------------
   logic [7:0] key_reg, key_next, cfg_sh_reg, cfg_sh_next, cfg_reg, cfg_next;
   logic [7:0] ival_sh_reg, ival_sh_next, ival_reg, ival_next, pin_reg, pin_next;
   logic [7:0] centi_reg, centi_next, sec_reg, sec_next, min_reg, min_next;
   logic [7:0] hour_reg, hour_next, icnt_reg, icnt_next, rdata_next;
   logic [7:0] div_reg, div_next;
   logic held_reg, held_next, midn_reg, midn_next, alarm_reg, alarm_next;
   logic pend_reg, pend_next, wake_next, irq_next, add_reg, add_next;
   logic pwe_next, cal_reg, cal_next, oe_next;
   logic [19:0] win_reg, win_next;
   logic [8:0] left_reg, left_next, mag2;
   logic [16:0] acc_reg, acc_next, acc_sum;
   logic [15:0] cacc_reg, cacc_next;
   logic [16:0] cal_sum;
   logic signed [8:0] trim_sum, trim_lim;
   logic time_ok, comp_tick, tick128, centi_tick, sec_c, min_c, hour_c, ipulse, fast;
   logic midn_ev, alarm_ev;
   logic [15:0] cal_inc;
   always_comb
   begin
      key_next = key_reg;
      cfg_sh_next = cfg_sh_reg;
      cfg_next = cfg_reg;
      ival_sh_next = ival_sh_reg;
      ival_next = ival_reg;
      pin_next = pin_reg;
      pwe_next = 1'b0;
      time_ok = key_reg == `RTC_KEY_TIME;
      if (sfr_wr)
      begin
         unique case (sfr_addr)
            `RTC_ADDR_KEY: key_next = sfr_wdata;
            `RTC_ADDR_CONFIG: cfg_sh_next = sfr_wdata;
            `RTC_ADDR_INTERVAL_COMPARE: ival_sh_next = sfr_wdata;
            `RTC_ADDR_POWER: pwe_next = key_reg == `RTC_KEY_POWER;
            `RTC_ADDR_PINCFG: if (time_ok) pin_next = sfr_wdata;
            default: ;
         endcase
      end
      // compensation: sum the trims, clamp, add or drop 2*|sum| pulses at the start of each window
      trim_sum = 9'($signed(nom_trim_reg)) + 9'($signed(therm_trim_reg));
      trim_lim = trim_sum > `RTC_TRIM_LIMIT ? `RTC_TRIM_LIMIT :
                 trim_sum < -`RTC_TRIM_LIMIT ? -`RTC_TRIM_LIMIT : trim_sum;
      mag2 = trim_lim[8] ? 9'((-trim_lim) << 1) : 9'(trim_lim << 1);
      win_next = win_reg;
      left_next = left_reg;
      add_next = 1'b0;
      comp_tick = add_reg;
      if (xt_tick)
      begin
         comp_tick = ~(trim_lim[8] && left_reg != 9'h000);
         add_next = ~trim_lim[8] && left_reg != 9'h000;
         if (left_reg != 9'h000)
            left_next = left_reg - 9'h001;
         if (win_reg == 20'(COMP_WINDOW - 1))
         begin
            win_next = 20'h00000;
            left_next = mag2;
         end
         else
            win_next = win_reg + 20'h00001;
      end
      // 128 Hz sync tick
      div_next = comp_tick ? div_reg + 8'h01 : div_reg;
      tick128 = comp_tick && div_reg == 8'hff;
      if (tick128)
      begin
         cfg_next[4:0] = cfg_sh_reg[4:0];
         ival_next = ival_sh_reg;
      end
      // time counters
      fast = pin_reg[6] && !deep_sleep_mode;
      acc_sum = acc_reg + (fast ? `RTC_CENTI_INC_FAST : `RTC_CENTI_INC_NORMAL);
      acc_next = acc_reg;
      centi_tick = 1'b0;
      if (comp_tick)
      begin
         centi_tick = acc_sum >= `RTC_ACC_WRAP;
         acc_next = centi_tick ? acc_sum - `RTC_ACC_WRAP : acc_sum;
      end
      sec_c = centi_tick && centi_reg == 8'h63;
      min_c = sec_c && sec_reg == 8'h3b;
      hour_c = min_c && min_reg == 8'h3b;
      midn_ev = hour_c && hour_reg == (cfg_reg[`RTC_CFG_HFMT] ? 8'hff : 8'h17);
      centi_next = centi_tick ? (sec_c ? 8'h00 : centi_reg + 8'h01) : centi_reg;
      sec_next = sec_c ? (min_c ? 8'h00 : sec_reg + 8'h01) : sec_reg;
      min_next = min_c ? (hour_c ? 8'h00 : min_reg + 8'h01) : min_reg;
      hour_next = hour_c ? (midn_ev ? 8'h00 : hour_reg + 8'h01) : hour_reg;
      if (sfr_wr && time_ok)
      begin
         if (sfr_addr == `RTC_ADDR_CENTI) centi_next = sfr_wdata;
         if (sfr_addr == `RTC_ADDR_SEC) sec_next = sfr_wdata;
         if (sfr_addr == `RTC_ADDR_MIN) min_next = sfr_wdata;
         if (sfr_addr == `RTC_ADDR_HOUR) hour_next = sfr_wdata;
      end
      // interval timer
      unique case (rtc_pkg::its_e'(cfg_reg[`RTC_CFG_ITS]))
         rtc_pkg::BASE_128HZ: ipulse = tick128;
         rtc_pkg::BASE_SEC: ipulse = sec_c;
         rtc_pkg::BASE_MIN: ipulse = min_c;
         rtc_pkg::BASE_HOUR: ipulse = hour_c;
      endcase
      icnt_next = icnt_reg;
      held_next = held_reg;
      alarm_ev = 1'b0;
      if (!cfg_reg[`RTC_CFG_INTERVAL_ENABLE])
      begin
         icnt_next = 8'h00;
         held_next = 1'b0;
      end
      else if (ipulse && !held_reg)
      begin
         alarm_ev = icnt_reg + 8'h01 == ival_reg;
         icnt_next = alarm_ev ? 8'h00 : icnt_reg + 8'h01;
         held_next = alarm_ev && cfg_reg[`RTC_CFG_SIT];
      end
      // flags: software clears by writing zero, a new event wins
      midn_next = midn_reg;
      alarm_next = alarm_reg;
      if (sfr_wr && sfr_addr == `RTC_ADDR_CONFIG)
      begin
         midn_next = midn_reg & sfr_wdata[`RTC_CFG_MIDNIGHT];
         alarm_next = alarm_reg & sfr_wdata[`RTC_CFG_ALARM];
      end
      midn_next = midn_next | midn_ev;
      alarm_next = alarm_next | alarm_ev;
      pend_next = midn_ev || alarm_ev || (pend_reg && !irq_ack);
      irq_next = pend_next && clock_irq_enable;
      wake_next = deep_sleep_mode && pend_next;
      // calibration output: phase accumulator toggles the pin
      unique case (rtc_pkg::cal_sel_e'(pin_reg[`RTC_PIN_FSEL]))
         rtc_pkg::CAL_1HZ: cal_inc = 16'h0002;
         rtc_pkg::CAL_512HZ: cal_inc = 16'h0400;
         rtc_pkg::CAL_500HZ: cal_inc = 16'h03e8;
         rtc_pkg::CAL_16K: cal_inc = 16'h8000;
      endcase
      cal_sum = {1'b0, cacc_reg} + {1'b0, cal_inc};
      cacc_next = cacc_reg;
      cal_next = cal_reg;
      if (comp_tick)
      begin
         cacc_next = {1'b0, cal_sum[14:0]};
         cal_next = cal_reg ^ (cal_sum[16:15] != 2'b00);
      end
      oe_next = pin_reg[`RTC_PIN_CALEN];
      rdata_next = sfr_rdata;
      if (sfr_rd)
      begin
         unique case (sfr_addr)
            `RTC_ADDR_CONFIG: rdata_next = {1'b0, midn_reg, alarm_reg, cfg_reg[4:0]};
            `RTC_ADDR_CENTI: rdata_next = centi_reg;
            `RTC_ADDR_SEC: rdata_next = sec_reg;
            `RTC_ADDR_MIN: rdata_next = min_reg;
            `RTC_ADDR_HOUR: rdata_next = hour_reg;
            `RTC_ADDR_INTERVAL_COMPARE: rdata_next = ival_reg;
            `RTC_ADDR_KEY: rdata_next = key_reg;
            `RTC_ADDR_NOMTRIM: rdata_next = nom_trim_reg;
            `RTC_ADDR_THERMTRIM: rdata_next = therm_trim_reg;
            `RTC_ADDR_PINCFG: rdata_next = pin_reg;
            default: rdata_next = 8'h00;
         endcase
      end
   end
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         {key_reg, cfg_sh_reg, cfg_reg, ival_sh_reg, ival_reg, pin_reg} <= '0;
         {centi_reg, sec_reg, min_reg, hour_reg, icnt_reg, div_reg} <= '0;
         {held_reg, midn_reg, alarm_reg, pend_reg, add_reg, cal_reg} <= '0;
         {win_reg, left_reg, acc_reg, cacc_reg} <= '0;
         {sfr_rdata, irq_req, wake_req, power_ctrl_we, power_ctrl_data} <= '0;
         {cal_pin_out, cal_pin_oe} <= '0;
      end
      else
      begin
         key_reg <= key_next;
         cfg_sh_reg <= cfg_sh_next;
         cfg_reg <= cfg_next;
         ival_sh_reg <= ival_sh_next;
         ival_reg <= ival_next;
         pin_reg <= pin_next;
         centi_reg <= centi_next;
         sec_reg <= sec_next;
         min_reg <= min_next;
         hour_reg <= hour_next;
         icnt_reg <= icnt_next;
         div_reg <= div_next;
         held_reg <= held_next;
         midn_reg <= midn_next;
         alarm_reg <= alarm_next;
         pend_reg <= pend_next;
         add_reg <= add_next;
         cal_reg <= cal_next;
         win_reg <= win_next;
         left_reg <= left_next;
         acc_reg <= acc_next;
         cacc_reg <= cacc_next;
         sfr_rdata <= rdata_next;
         irq_req <= irq_next;
         wake_req <= wake_next;
         power_ctrl_we <= pwe_next;
         power_ctrl_data <= sfr_wdata;
         cal_pin_out <= cal_next & oe_next;
         cal_pin_oe <= oe_next;
      end
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_power_key_gate: assert property (power_ctrl_we |-> $past(key_reg) == `RTC_KEY_POWER)
      else $error("power write without key");
   a_counter_lock: assert property (sfr_wr && sfr_addr == `RTC_ADDR_SEC && !time_ok && !sec_c
      |=> $stable(sec_reg))
      else $error("locked counter changed");
   a_hour_range: assert property (!cfg_reg[`RTC_CFG_HFMT] && !sfr_wr && hour_reg <= 8'h17
      |=> hour_reg <= 8'h17)
      else $error("hour left 24h range");
   a_midnight_flag: assert property (midn_ev |=> midn_reg && pend_reg)
      else $error("midnight not flagged");
   a_alarm_flag: assert property (alarm_ev |=> alarm_reg && pend_reg && icnt_reg == 8'h00)
      else $error("alarm not flagged");
   a_single_hold: assert property (alarm_ev && cfg_reg[`RTC_CFG_SIT] ##1 cfg_reg[`RTC_CFG_INTERVAL_ENABLE]
      |-> held_reg && icnt_reg == 8'h00)
      else $error("single shot not held");
   a_irq_gate: assert property (irq_req |-> $past(clock_irq_enable) && $past(pend_next))
      else $error("irq without enable");
   a_pend_clear: assert property (pend_reg && irq_ack && !midn_ev && !alarm_ev |=> !pend_reg)
      else $error("pending not cleared");
   a_wake_hold: assert property (deep_sleep_mode && pend_reg && !irq_ack |=> wake_req)
      else $error("wake dropped");
   a_sec_wrap: assert property (min_c |=> sec_reg == 8'h00)
      else $error("seconds wrap wrong");
   a_cal_quiet: assert property (!cal_pin_oe |-> !cal_pin_out)
      else $error("cal pin active while off");
   c_midnight: cover property (midn_ev);
   c_alarm_repeat: cover property (alarm_ev ##[1:1000] alarm_ev);
   c_wake: cover property (wake_req ##1 irq_ack);
   c_fast_cal: cover property (fast && cal_pin_oe);
endmodule : rtc_timekeeping_calibration

//--- sim/rtc_timekeeping_calibration_test.sv
`timescale 1ns/1ps
`include "rtc_params.svh"
module rtc_timekeeping_calibration_test;
   logic clk = 1'b0, rst_b = 1'b0, por_b = 1'b0, xtal_in = 1'b0, xtal_run = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, power_ctrl_data, rv, pw_data;
   logic sfr_wr = 1'b0, sfr_rd = 1'b0, clock_irq_enable = 1'b0, irq_ack = 1'b0;
   logic deep_sleep_mode = 1'b0, irq_req, wake_req, power_ctrl_we, cal_pin_out, cal_pin_oe;
   int n_errors = 0, n_tests = 0, cycles = 0, ticks = 0, pw_cnt = 0;
   logic [7:0] regs [11] = '{8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'hc1, 8'hf6, 8'hf7,
      8'hff, 8'h10};
   logic [7:0] keys [3] = '{8'h00, 8'ha7, 8'hea};
   int freq [4] = '{1, 512, 500, 16384};
   // ----------------------------------------
   // clocks, monitors, timeout
   // ----------------------------------------
   always #2 clk = ~clk;
   // crystal runs far faster than real so a hundredth fits in a few thousand cycles
   always #16.3 if (xtal_run) xtal_in = ~xtal_in;
   always @(posedge xtal_in) ticks++;
   always @(posedge clk)
   begin
      cycles++;
      if (power_ctrl_we === 1'b1)
      begin
         pw_cnt++;
         pw_data = power_ctrl_data;
      end
      if (cycles == 99000)
      begin
         n_errors++;
         give_verdict();
      end
   end
   rtc_timekeeping_calibration #(.COMP_WINDOW(512)) rtc_timekeeping_calibration_i (
      .clk(clk), .rst_b(rst_b), .por_b(por_b), .xtal_in(xtal_in), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
      .clock_irq_enable(clock_irq_enable), .irq_ack(irq_ack),
      .deep_sleep_mode(deep_sleep_mode), .irq_req(irq_req), .wake_req(wake_req),
      .power_ctrl_we(power_ctrl_we), .power_ctrl_data(power_ctrl_data),
      .cal_pin_out(cal_pin_out), .cal_pin_oe(cal_pin_oe));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // counters keep running, so a hundredths change during the read means read again
   task automatic read_time(output int t);
      logic [7:0] c0, s;
      do
      begin
         rd(`RTC_ADDR_CENTI);
         c0 = rv;
         rd(`RTC_ADDR_SEC);
         s = rv;
         rd(`RTC_ADDR_MIN);
         rd(`RTC_ADDR_HOUR);
         rd(`RTC_ADDR_CENTI);
      end
      while (rv !== c0);
      t = c0 + 100 * s;
   endtask : read_time
   task automatic count_toggles(input int n, output int cnt);
      int t0;
      logic last;
      t0 = ticks;
      cnt = 0;
      last = cal_pin_out;
      while (ticks - t0 < n)
      begin
         @(posedge clk) #1;
         if (cal_pin_out !== last) cnt++;
         last = cal_pin_out;
      end
   endtask : count_toggles
   // nominal trim from a measured percent error
   function automatic logic [7:0] trim_for(input real pct);
      return 8'(int'(5000.0 * pct));
   endfunction : trim_for
   // pulses added (positive) or removed per window for two trims
   function automatic int comp_pulses(input logic [7:0] a, input logic [7:0] b);
      int s;
      s = int'($signed(a)) + int'($signed(b));
      if (s > 124) s = 124;
      if (s < -124) s = -124;
      return 2 * s;
   endfunction : comp_pulses
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) #1;
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(posedge clk) #1;
      sfr_wr = 1'b0;
   endtask : wr
   task automatic kwr(input logic [7:0] a, input logic [7:0] d);
      wr(`RTC_ADDR_KEY, `RTC_KEY_TIME);
      wr(a, d);
      wr(`RTC_ADDR_KEY, 8'h00);
   endtask : kwr
   task automatic rd(input logic [7:0] a);
      @(posedge clk) #1;
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(posedge clk) #1;
      sfr_rd = 1'b0;
      rv = sfr_rdata;
   endtask : rd
   task automatic idle(input int n);
      repeat (n) @(posedge clk) #1;
   endtask : idle
   task automatic wait_wake(input int lim);
      for (int i = 0; i < lim && wake_req !== 1'b1; i++) @(posedge clk) #1;
   endtask : wait_wake
   task automatic ack();
      @(posedge clk) #1;
      irq_ack = 1'b1;
      @(posedge clk) #1;
      irq_ack = 1'b0;
      idle(2);
   endtask : ack
   // hundredths cleared first so no carry sneaks in while the rest is loaded
   task automatic set_time(input logic [7:0] h);
      kwr(`RTC_ADDR_CENTI, 8'h00);
      kwr(`RTC_ADDR_SEC, 8'h3b);
      kwr(`RTC_ADDR_MIN, 8'h3b);
      kwr(`RTC_ADDR_HOUR, h);
      kwr(`RTC_ADDR_CENTI, 8'h63);
   endtask : set_time
   task automatic resets(input bit por);
      @(posedge clk) #1;
      if (por) por_b = 1'b0;
      else rst_b = 1'b0;
      idle(4);
      rst_b = 1'b1;
      por_b = 1'b1;
   endtask : resets
   task automatic alarm_once(input logic [7:0] cfg, input int lim);
      wait_wake(lim);
      check("alarm wake", wake_req, 1'b1);
      rd(`RTC_ADDR_CONFIG);
      check("alarm flag", rv[5], 1'b1);
      ack();
      wr(`RTC_ADDR_CONFIG, cfg);
   endtask : alarm_once
   task automatic give_verdict();
      $display("errors %0d tests %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : give_verdict
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      logic [7:0] v, w, sec;
      int c, n, e, cnt, d0, d1;
      void'($urandom(28));
      idle(4);
      rst_b = 1'b1;
      por_b = 1'b1;
      foreach (regs[i])
      begin
         rd(regs[i]);
         check("reset value", rv, 8'h00);
      end
      v = 8'($urandom_range(1, 255));
      w = ~v;
      wr(`RTC_ADDR_THERMTRIM, v);
      wr(`RTC_ADDR_NOMTRIM, w);
      resets(1'b0);
      rd(`RTC_ADDR_THERMTRIM);
      check("thermal trim warm", rv, v);
      rd(`RTC_ADDR_NOMTRIM);
      check("nominal trim warm", rv, w);
      resets(1'b1);
      rd(`RTC_ADDR_THERMTRIM);
      check("thermal trim cold", rv, 8'h00);
      rd(`RTC_ADDR_NOMTRIM);
      check("nominal trim cold", rv, 8'h00);
      sec = 8'h00;
      foreach (keys[k])
      begin
         v = 8'($urandom_range(1, 59));
         w = ~v;
         n = pw_cnt;
         wr(`RTC_ADDR_KEY, keys[k]);
         wr(`RTC_ADDR_SEC, v);
         wr(`RTC_ADDR_POWER, w);
         wr(`RTC_ADDR_PINCFG, 8'h80);
         rd(`RTC_ADDR_SEC);
         if (keys[k] == `RTC_KEY_TIME) sec = v;
         check("sec write", rv, sec);
         check("power pulse", pw_cnt - n, keys[k] == `RTC_KEY_POWER);
         if (keys[k] == `RTC_KEY_POWER) check("power data", pw_data, w);
         check("pin enable", cal_pin_oe, keys[k] == `RTC_KEY_TIME);
      end
      kwr(`RTC_ADDR_PINCFG, 8'h00);
      xtal_run = 1'b1;
      deep_sleep_mode = 1'b1;
      set_time(8'h17);
      wait_wake(4000);
      check("wake at midnight", wake_req, 1'b1);
      check("irq while disabled", irq_req, 1'b0);
      rd(`RTC_ADDR_CONFIG);
      check("midnight flag", rv[6], 1'b1);
      rd(`RTC_ADDR_HOUR);
      check("hour wrap 24", rv, 8'h00);
      rd(`RTC_ADDR_MIN);
      check("minute wrap", rv, 8'h00);
      clock_irq_enable = 1'b1;
      idle(3);
      check("irq after enable", irq_req, 1'b1);
      check("wake held", wake_req, 1'b1);
      ack();
      check("irq after ack", irq_req, 1'b0);
      check("wake after ack", wake_req, 1'b0);
      wr(`RTC_ADDR_CONFIG, 8'h10);
      idle(4400);
      set_time(8'h17);
      idle(3000);
      check("no midnight at 24", wake_req, 1'b0);
      rd(`RTC_ADDR_HOUR);
      check("hour past 23", rv, 8'h18);
      set_time(8'hff);
      wait_wake(4000);
      check("wake 256h", wake_req, 1'b1);
      rd(`RTC_ADDR_HOUR);
      check("hour wrap 256", rv, 8'h00);
      ack();
      // interval alarm: repeating, then single shot
      c = $urandom_range(1, 3);
      wr(`RTC_ADDR_INTERVAL_COMPARE, 8'(c));
      wr(`RTC_ADDR_CONFIG, 8'h00);
      idle(4400);
      rd(`RTC_ADDR_CONFIG);
      check("enable off", rv[0], 1'b0);
      wr(`RTC_ADDR_CONFIG, 8'h01);
      for (int j = 0; j < 2; j++) alarm_once(8'h01, (c + 3) * 2100);
      wr(`RTC_ADDR_CONFIG, 8'h00);
      idle(4400);
      ack();
      wr(`RTC_ADDR_CONFIG, 8'h03);
      alarm_once(8'h03, (c + 3) * 2100);
      idle((c + 3) * 2100);
      check("single shot held", wake_req, 1'b0);
      wr(`RTC_ADDR_CONFIG, 8'h00);
      // interval counted in hours: only the hour carry may fire it
      wr(`RTC_ADDR_INTERVAL_COMPARE, 8'h01);
      idle(2200);
      rd(`RTC_ADDR_CONFIG);
      check("enable cleared", rv[0], 1'b0);
      wr(`RTC_ADDR_CONFIG, 8'h0d);
      idle(4400);
      check("no early hour alarm", wake_req, 1'b0);
      set_time(8'h05);
      alarm_once(8'h00, 3000);
      deep_sleep_mode = 1'b0;
      for (int f = 0; f < 4; f++)
      begin
         kwr(`RTC_ADDR_PINCFG, {1'b1, 2'(f), 5'h00});
         check("cal enable", cal_pin_oe, 1'b1);
         read_time(d0);
         count_toggles(256, cnt);
         read_time(d1);
         e = freq[f] / 64;
         check("cal toggles", cnt >= e - 1 && cnt <= e + 2, 1'b1);
         e = (f > 1) ? 96 : 0;
         d1 = (d1 - d0 + 6000) % 6000;
         check("count rate", d1 >= e && d1 <= e + 3, 1'b1);
      end
      // trims pushed past the limit both ways; pin still toggles on every tick
      for (int s = 0; s < 2; s++)
      begin
         v = trim_for(s ? -0.0248 : 0.0248);
         w = 8'($urandom_range(1, 100));
         if (s) w = -w;
         wr(`RTC_ADDR_NOMTRIM, v);
         wr(`RTC_ADDR_THERMTRIM, w);
         count_toggles(512, cnt);
         count_toggles(512, cnt);
         e = 512 + comp_pulses(v, w);
         check("comp pulses", cnt >= e - 2 && cnt <= e + 2, 1'b1);
      end
      kwr(`RTC_ADDR_PINCFG, 8'h00);
      idle(2);
      check("cal disabled", {cal_pin_oe, cal_pin_out}, 2'h0);
      kwr(`RTC_ADDR_CENTI, 8'h00);
      kwr(`RTC_ADDR_SEC, 8'h1e);
      read_time(d0);
      check("time rewritten", d0 / 100, 32'h0000001e);
      give_verdict();
   end
endmodule : rtc_timekeeping_calibration_test
